// ### core/asp_params.svh
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// Word layout.
`define ASP_WORD_BITS      24
`define ASP_WORD_MSB       23
`define ASP_BIPOLAR_ZERO   24'h00_0000

// Frame structure.
`define ASP_MASTER_BPF_MSB 5
`define ASP_HALF_LAST      6'h1F
`define ASP_FRAME_LAST     6'h3F
`define ASP_BPF_48         7'h30
`define ASP_BPF_CNT_ONE    7'h01

// Core cycles per frame (system clock ratio), per bit clock half period, and per bit at 48 bits a frame.
`define ASP_RATIO_256      11'h100
`define ASP_RATIO_384      11'h180
`define ASP_RATIO_512      11'h200
`define ASP_MID_256_384    11'h140
`define ASP_MID_384_512    11'h1C0
`define ASP_HALF_DIV_256   3'h2
`define ASP_HALF_DIV_384   3'h3
`define ASP_HALF_DIV_512   3'h4
`define ASP_DIV_ONE        3'h1
`define ASP_SPB_48         11'h008

// Drift limits in bit clocks.
`define ASP_LOSS_BCK_64    11'h006
`define ASP_LOSS_BCK_48    11'h005
`define ASP_KEEP_BCK_64    11'h005
`define ASP_KEEP_BCK_48    11'h004

// A frame longer than this is a stalled frame clock.
`define ASP_STALL_CYCLES   11'h258
`define ASP_PERIOD_ONE     11'h001

// Sample period counts.
`define ASP_WAIT_LAST      6'h1F
`define ASP_FADE_LAST      6'h2F
`define ASP_FADE_FULL      6'h30
`define ASP_FADE_DIV       32'sh0000_0030

`endif

// ### core/asp_pkg.sv
package asp_pkg;

    typedef enum logic [3:0] {
        ASP_MUTED = 4'b0001,
        ASP_WAIT  = 4'b0010,
        ASP_FADE  = 4'b0100,
        ASP_RUN   = 4'b1000
    } asp_state_type;

endpackage : asp_pkg

// ### core/asp_serial_port.sv
// Functional notes
// RL1: Left-justified: 24-bit word, MSB first.
// RL2: Clocks are inputs in slave, outputs in master.
// RL3: Slave samples frame clock on bit rises.
// RL4: Data updates after each bit clock fall.
// RL5: Frame clock transition also launches a bit.
// RL6: Master frame clock changes only on falls.
// RL7: Partner keeps frame clock locked to system.
// RL8: Large drift stops output within one frame.
// RL9: Zero code output until lock returns.
// RL10: Small drift causes no disturbance at all.
// RL11: Valid output only after 32 frames.
// RL12: Fade in over 48 frames to full.
// RL13: Lock loss aborts fade, zero at once.
// RL14: Fade restarts from mute after 32 frames.
// RL15: Left in frame-high half, zero padding.
// RL16: Master makes 64 bit clocks per frame.
// RL17: Partner gives 64, or 48 at 384x.
// RL18: Mode pins choose slave or master ratio.
// RL19: Format low selects I2S, one-bit delay.
`include "asp_params.svh"

module asp_serial_port
    import asp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        bitClockIn,
    input  wire logic        frameClockIn,
    input  wire logic        formatSelect,
    input  wire logic        modeSelHi,
    input  wire logic        modeSelLo,
    input  wire logic [23:0] leftSample,
    input  wire logic [23:0] rightSample,
    output logic             bitClockOut,
    output logic             bitClockOe,
    output logic             frameClockOut,
    output logic             frameClockOe,
    output logic             serialData,
    output logic             sampleTaken,
    output logic             lockValid
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] aspScale(input logic [23:0] s, input logic [5:0] g);
        logic signed [31:0] p;
        p = $signed({{8{s[23]}}, s}) * $signed({26'h000_0000, g});
        p = p / `ASP_FADE_DIV;
        return p[23:0];
    endfunction : aspScale

    function automatic logic [10:0] aspLimit(input logic [10:0] nom, input logic b48,
                                             input logic loss);
        logic [10:0] spb;
        logic [10:0] k;
        logic [21:0] prod;
        spb  = b48 ? `ASP_SPB_48 : {6'h00, nom[10:6]};
        k    = loss ? (b48 ? `ASP_LOSS_BCK_48 : `ASP_LOSS_BCK_64)
                    : (b48 ? `ASP_KEEP_BCK_48 : `ASP_KEEP_BCK_64);
        prod = spb * k;
        return prod[10:0];
    endfunction : aspLimit

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic [4:0] pinMeta_r;
    logic [4:0] pinSync_r;
    logic       bckDly_r;
    logic       frameDly_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pinMeta_r <= 5'h00;
            pinSync_r <= 5'h00;
        end else begin
            pinMeta_r <= {bitClockIn, frameClockIn, formatSelect, modeSelHi, modeSelLo};
            pinSync_r <= pinMeta_r;
        end
    end

    logic fmtLj;
    logic master;
    assign fmtLj  = pinSync_r[2];
    assign master = pinSync_r[1] | pinSync_r[0]; // RL18

    logic [2:0] halfDiv;
    always_comb begin
        unique case ({pinSync_r[1], pinSync_r[0]}) // RL18
            2'b01:   halfDiv = `ASP_HALF_DIV_512;
            2'b10:   halfDiv = `ASP_HALF_DIV_384;
            default: halfDiv = `ASP_HALF_DIV_256;
        endcase
    end

    logic [10:0] masterRatio;
    assign masterRatio = (halfDiv == `ASP_HALF_DIV_512) ? `ASP_RATIO_512 :
                         (halfDiv == `ASP_HALF_DIV_384) ? `ASP_RATIO_384 : `ASP_RATIO_256;

    ////////////////////////////////////////////////////////////////////////////
    // Master clock generation from the core clock.
    logic [2:0] divCnt_r;
    logic [5:0] masterBit_r;
    logic       bitClockOut_r;
    logic       frameClockOut_r;

    always_ff @(posedge core_clk) begin
        if (reset || !master) begin
            divCnt_r        <= 3'h0;
            masterBit_r     <= 6'h00;
            bitClockOut_r   <= 1'b0;
            frameClockOut_r <= 1'b0;
        end else if (divCnt_r == halfDiv - `ASP_DIV_ONE) begin
            divCnt_r      <= 3'h0;
            bitClockOut_r <= !bitClockOut_r;
            if (bitClockOut_r) begin
                masterBit_r <= masterBit_r + 6'h01; // RL16
                if (masterBit_r == `ASP_HALF_LAST || masterBit_r == `ASP_FRAME_LAST) begin
                    frameClockOut_r <= !frameClockOut_r; // RL6
                end
            end
        end else begin
            divCnt_r <= divCnt_r + 3'h1;
        end
    end

    assign bitClockOut   = bitClockOut_r;
    assign frameClockOut = frameClockOut_r;
    assign bitClockOe    = master; // RL2
    assign frameClockOe  = master; // RL2

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on whichever party owns the clocks.
    logic bckLvl;
    logic frameLvl;
    logic bckRise;
    logic bckFall;
    logic frameEdge;
    assign bckLvl    = master ? bitClockOut_r : pinSync_r[4];
    assign frameLvl  = master ? frameClockOut_r : pinSync_r[3];
    assign bckRise   = bckLvl && !bckDly_r;
    assign bckFall   = !bckLvl && bckDly_r;
    assign frameEdge = frameLvl != frameDly_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            bckDly_r   <= 1'b0;
            frameDly_r <= 1'b0;
        end else begin
            bckDly_r   <= bckLvl;
            frameDly_r <= frameLvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame period measurement against the system (core) clock.
    logic        frameSampled_r;
    logic [10:0] periodCnt_r;
    logic [6:0]  bitCnt_r;
    logic        frameTick;
    logic        stall;
    assign frameTick = bckRise && frameLvl && !frameSampled_r;
    assign stall     = periodCnt_r > `ASP_STALL_CYCLES;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            frameSampled_r <= 1'b0;
            periodCnt_r    <= `ASP_PERIOD_ONE;
            bitCnt_r       <= 7'h00;
        end else begin
            if (bckRise) begin
                frameSampled_r <= frameLvl; // RL3
            end
            if (frameTick) begin
                periodCnt_r <= `ASP_PERIOD_ONE;
                bitCnt_r    <= `ASP_BPF_CNT_ONE;
            end else begin
                if (!stall) begin
                    periodCnt_r <= periodCnt_r + `ASP_PERIOD_ONE;
                end
                if (bckRise && bitCnt_r != 7'h7F) begin
                    bitCnt_r <= bitCnt_r + 7'h01;
                end
            end
        end
    end

    // The slave ratio is taken as the nearest legal one to what was measured.
    logic [10:0] nominal;
    logic [10:0] deviation;
    logic [10:0] lossLimit;
    logic [10:0] keepLimit;
    logic        driftLoss;
    logic        driftKeep;
    logic        b48Now;
    assign b48Now    = !master && (bitCnt_r == `ASP_BPF_48);
    assign nominal   = master ? masterRatio :
                       (periodCnt_r < `ASP_MID_256_384) ? `ASP_RATIO_256 :
                       (periodCnt_r < `ASP_MID_384_512) ? `ASP_RATIO_384 : `ASP_RATIO_512;
    assign deviation = (periodCnt_r > nominal) ? periodCnt_r - nominal
                                               : nominal - periodCnt_r;
    assign lossLimit = aspLimit(nominal, b48Now, 1'b1);
    assign keepLimit = aspLimit(nominal, b48Now, 1'b0);
    assign driftLoss = stall || (frameTick && deviation > lossLimit); // RL8
    assign driftKeep = frameTick && deviation < keepLimit; // RL10

    ////////////////////////////////////////////////////////////////////////////
    // Lock, wait and fade sequencing.
    asp_state_type state_r;
    logic [5:0]    waitCnt_r;
    logic [5:0]    fadeCnt_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r   <= ASP_MUTED;
            waitCnt_r <= 6'h00;
            fadeCnt_r <= 6'h00;
        end else if (driftLoss) begin
            state_r   <= ASP_MUTED; // RL8 RL13
            waitCnt_r <= 6'h00;
            fadeCnt_r <= 6'h00;
        end else begin
            unique case (state_r)
                ASP_MUTED: if (driftKeep) begin
                    state_r   <= ASP_WAIT; // RL9
                    waitCnt_r <= 6'h00;
                end
                ASP_WAIT: if (frameTick) begin
                    if (waitCnt_r == `ASP_WAIT_LAST) begin
                        state_r   <= ASP_FADE; // RL11 RL14
                        fadeCnt_r <= 6'h00;
                    end else begin
                        waitCnt_r <= waitCnt_r + 6'h01;
                    end
                end
                ASP_FADE: if (frameTick) begin
                    if (fadeCnt_r == `ASP_FADE_LAST) begin
                        state_r <= ASP_RUN; // RL12
                    end
                    fadeCnt_r <= fadeCnt_r + 6'h01;
                end
                ASP_RUN: ;
            endcase
        end
    end

    logic muted;
    assign muted     = state_r == ASP_MUTED;
    assign lockValid = state_r != ASP_MUTED;

    ////////////////////////////////////////////////////////////////////////////
    // Serial word output.
    logic        isLeft;
    logic [5:0]  gain;
    logic [23:0] wordNow;
    logic [23:0] rightHold_r;
    logic [23:0] shift_r;
    logic        serialOut_r;
    logic        armed_r;
    logic        sampleTaken_r;

    assign isLeft  = fmtLj ? frameLvl : !frameLvl; // RL15 RL19
    assign gain    = (state_r == ASP_RUN) ? `ASP_FADE_FULL : fadeCnt_r;
    assign wordNow = muted ? `ASP_BIPOLAR_ZERO
                           : aspScale(isLeft ? leftSample : rightHold_r, gain); // RL9 RL12

    // A fall before the first rise after a frame edge belongs to the old half and
    // is ignored, so skew between the two pins cannot drop the MSB.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            shift_r       <= 24'h00_0000;
            serialOut_r   <= 1'b0;
            armed_r       <= 1'b0;
            rightHold_r   <= 24'h00_0000;
            sampleTaken_r <= 1'b0;
        end else begin
            sampleTaken_r <= frameEdge && isLeft;
            if (bckRise) begin
                armed_r <= 1'b1;
            end
            if (muted) begin
                shift_r     <= 24'h00_0000; // RL13
                serialOut_r <= 1'b0; // RL9
            end else if (frameEdge) begin
                armed_r <= 1'b0;
                if (isLeft) begin
                    rightHold_r <= rightSample;
                end
                if (fmtLj) begin
                    serialOut_r <= wordNow[`ASP_WORD_MSB]; // RL1 RL5
                    shift_r     <= {wordNow[`ASP_WORD_MSB-1:0], 1'b0};
                end else begin
                    serialOut_r <= 1'b0; // RL19
                    shift_r     <= wordNow;
                end
            end else if (bckFall && armed_r) begin
                serialOut_r <= shift_r[`ASP_WORD_MSB]; // RL4 RL15
                shift_r     <= {shift_r[`ASP_WORD_MSB-1:0], 1'b0};
            end
        end
    end

    assign serialData  = serialOut_r;
    assign sampleTaken = sampleTaken_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [6:0] fallsSeen_r;
    logic       frameSeen_r;
    always_ff @(posedge core_clk) begin
        if (reset || !master) begin
            fallsSeen_r <= 7'h00;
            frameSeen_r <= 1'b0;
        end else if (frameClockOut_r && !frameDly_r) begin
            // The frame rise coincides with a bit clock fall, so that fall counts here.
            fallsSeen_r <= 7'h01;
            frameSeen_r <= 1'b1;
        end else if (bckFall) begin
            fallsSeen_r <= fallsSeen_r + 7'h01;
        end
    end

    sequence s_fade_start;
        $rose(state_r == ASP_FADE);
    endsequence
    sequence s_run_start;
        $rose(state_r == ASP_RUN);
    endsequence

    property p_mute_zero;
        @(posedge core_clk) disable iff (reset) muted |=> !serialData;
    endproperty
    a_mute_zero: assert property (p_mute_zero) else $error("data not zero while muted"); // RL9 RL13

    property p_wait_len;
        @(posedge core_clk) disable iff (reset) s_fade_start |-> $past(waitCnt_r) == 6'h1F;
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("wait not 32 frames"); // RL11 RL14

    property p_fade_len;
        @(posedge core_clk) disable iff (reset) s_run_start |-> fadeCnt_r == 6'h30;
    endproperty
    a_fade_len: assert property (p_fade_len) else $error("fade not 48 frames"); // RL12

    property p_frame_on_fall;
        @(posedge core_clk) disable iff (reset)
            (master && $past(master) && $changed(frameClockOut)) |-> $fell(bitClockOut);
    endproperty
    a_frame_on_fall: assert property (p_frame_on_fall) else $error("frame moved off fall"); // RL6

    property p_master_64;
        @(posedge core_clk) disable iff (reset)
            (frameSeen_r && frameClockOut_r && !frameDly_r) |-> fallsSeen_r == 7'h40;
    endproperty
    a_master_64: assert property (p_master_64) else $error("master frame not 64 bits"); // RL16

    property p_oe_mode;
        @(posedge core_clk) disable iff (reset)
            (bitClockOe == master) && (frameClockOe == master);
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("clock direction wrong"); // RL2

    property p_data_timing;
        @(posedge core_clk) disable iff (reset)
            $changed(serialData) |-> $past(bckFall || frameEdge || muted);
    endproperty
    a_data_timing: assert property (p_data_timing) else $error("data changed off edge"); // RL4 RL5

    property p_lose;
        @(posedge core_clk) disable iff (reset) driftLoss |=> muted;
    endproperty
    a_lose: assert property (p_lose) else $error("drift did not mute"); // RL8

    property p_keep;
        @(posedge core_clk) disable iff (reset)
            (state_r == ASP_RUN && driftKeep && !stall) |=> state_r == ASP_RUN;
    endproperty
    a_keep: assert property (p_keep) else $error("small drift disturbed output"); // RL10

    property p_lj_first;
        @(posedge core_clk) disable iff (reset)
            (fmtLj && frameEdge && !muted && !driftLoss) |=> serialData == $past(wordNow[23]);
    endproperty
    a_lj_first: assert property (p_lj_first) else $error("MSB not after frame edge"); // RL1 RL5

endmodule : asp_serial_port

// ### tb/asp_audio_partner.sv
module asp_audio_partner (
    input  wire logic        active,
    input  wire logic        leftJust,
    input  wire logic        serialData,
    output logic             bitClock,
    output logic             frameClock,
    output logic [23:0]      leftWord,
    output logic [23:0]      rightWord,
    output logic             padOnes
);
    timeunit 1ns;
    timeprecision 1ps;

    int extraBits = 0;

    task automatic stretch_next(input int n);
        extraBits = n;
    endtask : stretch_next

    task automatic clear_pad();
        padOnes = 1'b0;
    endtask : clear_pad

    ////////////////////////////////////////////////////////////////////////////////
    // The link clock stands still while idle. The odd start offset keeps its phase
    // unrelated to the core clock, as a real external controller would be.
    initial begin
        int nBits;
        logic [23:0] w;
        bitClock   = 1'b0;
        frameClock = 1'b0;
        leftWord   = '0;
        rightWord  = '0;
        padOnes    = 1'b0;
        #13;
        forever begin
            if (!active) begin
                #400;
            end else begin
                for (int h = 0; h < 2; h++) begin
                    if (h == 0) begin
                        nBits     = 32 + extraBits;
                        extraBits = 0;
                    end else begin
                        nBits = 32;
                    end
                    frameClock = (h == 0);
                    w = '0;
                    for (int b = 0; b < nBits; b++) begin
                        #200;
                        bitClock = 1'b1;
                        if (leftJust ? (b < 24) : (b >= 1 && b <= 24)) begin
                            w[leftJust ? 23 - b : 24 - b] = serialData;
                        end else if (serialData !== 1'b0) begin
                            padOnes = 1'b1;
                        end
                        #200;
                        bitClock = 1'b0;
                    end
                    if ((h == 0) == leftJust) begin
                        leftWord = w;
                    end else begin
                        rightWord = w;
                    end
                end
            end
        end
    end
endmodule : asp_audio_partner

// ### tb/asp_serial_port_tb_top.sv
module asp_serial_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int          FRAME_CYCLES = 512;
    localparam logic [23:0] LEFT_VAL     = 24'h5A_C3F1;
    localparam logic [23:0] RIGHT_VAL    = 24'h35_0E7C;

    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        formatSelect = 1'b1;
    logic        modeSelHi = 1'b0;
    logic        modeSelLo = 1'b0;
    logic        partActive = 1'b0;
    logic        partLj = 1'b1;
    logic        bitClockOut, bitClockOe, frameClockOut, frameClockOe;
    logic        serialData, sampleTaken, lockValid, partBit, partFrame, padOnes;
    logic        bitPrev, framePrev, lockPrev;
    logic [23:0] leftWord, rightWord;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycBit = 0, cycFrame = 0, bitsSeen = 0;
    int          bitPeriod = 0, framePeriod = 0, frameBits = 0;
    int          offFall = 0, zeroLeak = 0, lockDrops = 0;
    int          cycTake = 0, takePeriod = 0;

    always #25 core_clk = ~core_clk;

    asp_serial_port dut_u (
        .core_clk      (core_clk),
        .reset         (reset),
        .bitClockIn    (bitClockOe ? bitClockOut : partBit),
        .frameClockIn  (frameClockOe ? frameClockOut : partFrame),
        .formatSelect  (formatSelect),
        .modeSelHi     (modeSelHi),
        .modeSelLo     (modeSelLo),
        .leftSample    (LEFT_VAL),
        .rightSample   (RIGHT_VAL),
        .bitClockOut   (bitClockOut),
        .bitClockOe    (bitClockOe),
        .frameClockOut (frameClockOut),
        .frameClockOe  (frameClockOe),
        .serialData    (serialData),
        .sampleTaken   (sampleTaken),
        .lockValid     (lockValid)
    );

    asp_audio_partner partner_u (
        .active     (partActive),
        .leftJust   (partLj),
        .serialData (serialData),
        .bitClock   (partBit),
        .frameClock (partFrame),
        .leftWord   (leftWord),
        .rightWord  (rightWord),
        .padOnes    (padOnes)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Measures the master clocks, counts events that must never happen, and counts lock drops.
    always @(posedge core_clk) begin
        bitPrev   <= bitClockOut;
        framePrev <= frameClockOut;
        lockPrev  <= lockValid;
        cycBit    <= cycBit + 1;
        cycFrame  <= cycFrame + 1;
        cycTake   <= cycTake + 1;
        if (sampleTaken === 1'b1) begin
            takePeriod <= cycTake;
            cycTake    <= 1;
        end
        if (bitClockOut === 1'b1 && bitPrev === 1'b0) begin
            bitPeriod <= cycBit;
            cycBit    <= 1;
            bitsSeen  <= bitsSeen + 1;
        end
        if (frameClockOut === 1'b1 && framePrev === 1'b0) begin
            framePeriod <= cycFrame;
            cycFrame    <= 1;
            frameBits   <= bitsSeen;
            bitsSeen    <= 0;
        end
        if (frameClockOe === 1'b1 && frameClockOut !== framePrev
            && !(bitPrev === 1'b1 && bitClockOut === 1'b0)) begin
            offFall <= offFall + 1;
        end
        // Muting clears the data one cycle after the state drops, within the frame.
        if (reset === 1'b0 && lockPrev !== 1'b1 && lockValid !== 1'b1
            && serialData !== 1'b0) begin
            zeroLeak <= zeroLeak + 1;
        end
        if (reset === 1'b0 && lockPrev === 1'b1 && lockValid === 1'b0) begin
            lockDrops <= lockDrops + 1;
        end
    end

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("Checks made %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic apply_reset();
        reset = 1'b1;
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask : apply_reset

    task automatic wait_frames(input int n);
        repeat (n * FRAME_CYCLES) @(negedge core_clk);
    endtask : wait_frames

    ////////////////////////////////////////////////////////////////////////////////
    // Master: bit clock from core clock divided by one 64th of the selected ratio, 64 bits a frame.
    task automatic run_master(input logic hi, input logic lo, input int period);
        modeSelHi = hi;
        modeSelLo = lo;
        apply_reset();
        check("bit clock enable", bitClockOe, 1'b1);
        check("frame clock enable", frameClockOe, 1'b1);
        repeat (3 * 64 * period + 40) @(negedge core_clk);
        check("bit period", 24'(bitPeriod), 24'(period));
        check("frame period", 24'(framePeriod), 24'(64 * period));
        check("bits per frame", 24'(frameBits), 24'd64);
        check("sample taken period", 24'(takePeriod), 24'(64 * period));
        check("frame off fall", 24'(offFall), 24'd0);
    endtask : run_master

    ////////////////////////////////////////////////////////////////////////////////
    // Slave: lock, fade aborted by a loss, relock in I2S, small drift, back to left-justified.
    task automatic run_slave();
        int n;
        modeSelHi    = 1'b0;
        modeSelLo    = 1'b0;
        formatSelect = 1'b1;
        apply_reset();
        check("slave bit enable", bitClockOe, 1'b0);
        check("data after reset", serialData, 1'b0);
        check("lock after reset", lockValid, 1'b0);
        partActive = 1'b1;
        for (n = 0; n < 6 * FRAME_CYCLES && lockValid !== 1'b1; n++) @(negedge core_clk);
        check("first lock", lockValid, 1'b1);
        wait_frames(10);
        check("left during wait", leftWord, 24'h00_0000);
        wait_frames(30);
        n = lockDrops;
        partner_u.stretch_next(8);
        wait_frames(3);
        check("loss in fade", 24'(lockDrops - n), 24'd1);
        formatSelect = 1'b0;
        partLj       = 1'b0;
        for (n = 0; n < 6 * FRAME_CYCLES && lockValid !== 1'b1; n++) @(negedge core_clk);
        wait_frames(12);
        partner_u.clear_pad();
        check("left after relock", leftWord, 24'h00_0000);
        check("right after relock", rightWord, 24'h00_0000);
        wait_frames(40);
        check("mid fade", 24'(leftWord > 0 && leftWord < LEFT_VAL), 24'd1);
        wait_frames(40);
        check("i2s left", leftWord, LEFT_VAL);
        check("i2s right", rightWord, RIGHT_VAL);
        n = lockDrops;
        partner_u.stretch_next(3);
        wait_frames(4);
        check("small drift drops", 24'(lockDrops - n), 24'd0);
        check("small drift left", leftWord, LEFT_VAL);
        formatSelect = 1'b1;
        partLj       = 1'b1;
        wait_frames(3);
        partner_u.clear_pad();
        wait_frames(2);
        check("lj left", leftWord, LEFT_VAL);
        check("lj right", rightWord, RIGHT_VAL);
        check("pad ones", padOnes, 1'b0);
        check("data while muted", 24'(zeroLeak), 24'd0);
    endtask : run_slave

    initial begin
        #5_000_000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        @(negedge core_clk);
        run_master(1'b0, 1'b1, 8);
        run_master(1'b1, 1'b0, 6);
        run_master(1'b1, 1'b1, 4);
        run_slave();
        report_and_stop();
    end
endmodule : asp_serial_port_tb_top
